// ==== rtl/dtec_channel.sv ====
// dtec_channel: one 8-bit count-up counter with preload, edge logic and pulse measurement
// assumes pin_i is already synchronised and tick_i is a one-cycle clock enable pulse
`timescale 1ns/10ps
module dtec_channel
  import dtec_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic [1:0] mode_i,
  input wire logic run_i,
  input wire logic edge_sel_i,
  input wire logic tick_i,
  input wire logic hold_i,
  // synchronised pin
  input wire logic pin_i,
  // preload write
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  // state
  output logic [7:0] count_o,
  output logic ovf_o,
  output logic done_o
);
  logic [7:0] preload_r;
  logic pin_d_r;
  dtec_pw_e pw_r;
  dtec_pw_e pw_nxt;
  wire rise = pin_i & ~pin_d_r;
  wire fall = ~pin_i & pin_d_r;
  wire ev_edge = edge_sel_i ? fall : rise;
  wire start_edge = edge_sel_i ? rise : fall;
  wire stop_edge = edge_sel_i ? fall : rise;
  wire is_event = (mode_i == DTEC_MODE_EVENT);
  wire is_timer = (mode_i == DTEC_MODE_TIMER);
  wire is_pulse = (mode_i == DTEC_MODE_PULSE);
  // pin ignored in timer mode; unused mode never counts
  wire inc_raw = (is_event & ev_edge) | (is_timer & tick_i) |
                 (is_pulse & tick_i & (pw_r == DTEC_PW_COUNT));
  wire inc = run_i & ~hold_i & inc_raw;
  wire wrap = inc & (count_o == DTEC_CNT_MAX);

  always_comb begin
    pw_nxt = pw_r;
    done_o = 1'b0;
    if (!(run_i && is_pulse)) begin
      pw_nxt = DTEC_PW_ARM;
    end else begin
      unique case (pw_r)
        DTEC_PW_ARM: if (start_edge) pw_nxt = DTEC_PW_COUNT;
        DTEC_PW_COUNT: begin
          if (stop_edge) begin
            pw_nxt = DTEC_PW_DONE;
            done_o = 1'b1;
          end
        end
        DTEC_PW_DONE: pw_nxt = DTEC_PW_DONE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      preload_r <= DTEC_CNT_RST;
      count_o <= DTEC_CNT_RST;
      pin_d_r <= 1'b0;
      pw_r <= DTEC_PW_ARM;
      ovf_o <= 1'b0;
    end else begin
      pin_d_r <= pin_i;
      pw_r <= pw_nxt;
      ovf_o <= wrap;
      if (wr_i) begin
        preload_r <= wdata_i;
      end
      if (wr_i && !run_i) begin
        count_o <= wdata_i;
      end else if (wrap) begin
        count_o <= preload_r;
      end else if (inc) begin
        count_o <= count_o + 8'h01;
      end
    end
  end

  a_hold_freeze: assert property (@(posedge clk_i) disable iff (rst_i)
    hold_i && !wr_i |=> $stable(count_o)) else $error("count moved while held");
  a_off_mode_idle: assert property (@(posedge clk_i) disable iff (rst_i)
    mode_i == DTEC_MODE_OFF && !wr_i |=> $stable(count_o))
    else $error("count moved in unused mode");
  a_wrap_reload: assert property (@(posedge clk_i) disable iff (rst_i)
    wrap && !wr_i |=> count_o == $past(preload_r) && ovf_o)
    else $error("overflow did not reload");
  a_timer_tick: assert property (@(posedge clk_i) disable iff (rst_i)
    is_timer && run_i && tick_i && !hold_i && !wr_i && count_o != DTEC_CNT_MAX
    |=> count_o == $past(count_o) + 8'h01) else $error("timer tick lost");
  a_stopped_load: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && !run_i |=> count_o == $past(wdata_i)) else $error("idle preload not loaded");
  a_run_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_i && run_i && !inc |=> $stable(count_o)) else $error("running write hit counter");
endmodule

// ==== rtl/dtec_pkg.sv ====
// dtec_pkg: register map, control field layout and reset values of the dual timer
// assumes a classic wishbone slave with 8-bit data in the low lane of a 32-bit bus
package dtec_pkg;
  // register indices; any offset not a multiple of four, so byte address is index*4
  localparam logic [7:0] DTEC_IDX_CNT0 = 8'h0d;
  localparam logic [7:0] DTEC_IDX_CTL0 = 8'h0e;
  localparam logic [7:0] DTEC_IDX_CNT1 = 8'h10;
  localparam logic [7:0] DTEC_IDX_CTL1 = 8'h11;
  // control fields
  localparam int DTEC_BIT_EDGE = 3;
  localparam int DTEC_BIT_RUN = 4;
  localparam int DTEC_BIT_CSEL = 5;
  localparam int DTEC_BIT_MODE_LO = 6;
  localparam int DTEC_BIT_MODE_HI = 7;
  localparam logic [2:0] DTEC_CTL_UNUSED_MASK = 3'h0;
  // reset values: counter off, mode unused
  localparam logic [7:0] DTEC_CTL_RST = 8'h08;
  localparam logic [7:0] DTEC_CNT_RST = 8'h00;
  localparam logic [7:0] DTEC_CNT_MAX = 8'hff;
  // prescale for system clock divided by four
  localparam int DTEC_DIV4 = 4;
  localparam logic [1:0] DTEC_DIV4_LAST = 2'(DTEC_DIV4 - 1);
  typedef enum logic [1:0] {
    DTEC_MODE_OFF,
    DTEC_MODE_EVENT,
    DTEC_MODE_TIMER,
    DTEC_MODE_PULSE
  } dtec_mode_e;
  // pulse width measurement progress
  typedef enum logic [1:0] {
    DTEC_PW_ARM,
    DTEC_PW_COUNT,
    DTEC_PW_DONE
  } dtec_pw_e;
endpackage

// ==== rtl/dtec_top.sv ====
// dtec_top: two timer/event counters behind a classic wishbone slave
// assumes pins are asynchronous; tick sources are one-cycle pulses on clk_i
//
// Added by the designer: register access over Wishbone.
`timescale 1ns/10ps
module dtec_top
  import dtec_pkg::*;
#(
  // build options: 0 system clock, 1 system clock/4
  parameter bit C0_SYS_DIV4 = 1'b0,
  // 0 counter0 overflow, 1 system clock, 2 time base
  parameter logic [1:0] C1_OPT_SRC = 2'h0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // tick sources and pins
  input wire logic rtc_tick_i,
  input wire logic tbase_tick_i,
  input wire logic counter0_pin_i,
  input wire logic counter1_pin_i,
  // overflow request pulses
  output logic counter0_ovf_o,
  output logic counter1_ovf_o
);
  logic [7:0] ctl0_r;
  logic [7:0] ctl1_r;
  logic [1:0] div_r;
  logic [1:0] sync0_r;
  logic [1:0] sync1_r;
  logic [7:0] cnt0;
  logic [7:0] cnt1;
  logic ovf0;
  logic ovf1;
  logic done0;
  logic done1;

  ////////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire aligned = (wb_adr_i[1:0] == 2'h0);
  wire [7:0] idx = {2'h0, wb_adr_i[7:2]};
  wire hit_c0 = aligned & (idx == DTEC_IDX_CNT0);
  wire hit_k0 = aligned & (idx == DTEC_IDX_CTL0);
  wire hit_c1 = aligned & (idx == DTEC_IDX_CNT1);
  wire hit_k1 = aligned & (idx == DTEC_IDX_CTL1);
  wire hit = hit_c0 | hit_k0 | hit_c1 | hit_k1;
  wire wr_en = req & wb_we_i & wb_sel_i[0];
  wire wr_c0 = wr_en & hit_c0;
  wire wr_c1 = wr_en & hit_c1;
  wire wr_k0 = wr_en & hit_k0;
  wire wr_k1 = wr_en & hit_k1;
  // holding for the whole bus cycle may swallow a tick; a read is never torn
  wire hold0 = wb_cyc_i & wb_stb_i & ~wb_we_i & hit_c0;
  wire hold1 = wb_cyc_i & wb_stb_i & ~wb_we_i & hit_c1;
  wire [7:0] rd_mux = hit_c0 ? cnt0 :
                      hit_k0 ? {ctl0_r[7:3], DTEC_CTL_UNUSED_MASK} :
                      hit_c1 ? cnt1 :
                      hit_k1 ? {ctl1_r[7:3], DTEC_CTL_UNUSED_MASK} : 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // clock sources
  wire sys_q = (div_r == DTEC_DIV4_LAST);
  wire c0_sys = C0_SYS_DIV4 ? sys_q : 1'b1;
  wire tick0 = ctl0_r[DTEC_BIT_CSEL] ? c0_sys : rtc_tick_i;
  wire c1_opt = (C1_OPT_SRC == 2'h0) ? ovf0 :
                (C1_OPT_SRC == 2'h1) ? 1'b1 : tbase_tick_i;
  wire tick1 = ctl1_r[DTEC_BIT_CSEL] ? sys_q : c1_opt;

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_r <= 2'h0;
      sync0_r <= 2'h0;
      sync1_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
      sync0_r <= {sync0_r[0], counter0_pin_i};
      sync1_r <= {sync1_r[0], counter1_pin_i};
    end
  end

  // the write wins over the auto clear so software can rearm in the done cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl0_r <= DTEC_CTL_RST;
      ctl1_r <= DTEC_CTL_RST;
    end else begin
      if (wr_k0) ctl0_r <= {wb_dat_i[7:3], 3'h0};
      else if (done0) ctl0_r[DTEC_BIT_RUN] <= 1'b0;
      if (wr_k1) ctl1_r <= {wb_dat_i[7:3], 3'h0};
      else if (done1) ctl1_r[DTEC_BIT_RUN] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      wb_dat_o <= {24'h0, rd_mux};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      counter0_ovf_o <= 1'b0;
      counter1_ovf_o <= 1'b0;
    end else begin
      counter0_ovf_o <= ovf0;
      counter1_ovf_o <= ovf1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // the two channels
  dtec_channel u_ch0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(ctl0_r[DTEC_BIT_MODE_HI:DTEC_BIT_MODE_LO]),
    .run_i(ctl0_r[DTEC_BIT_RUN]),
    .edge_sel_i(ctl0_r[DTEC_BIT_EDGE]),
    .tick_i(tick0),
    .hold_i(hold0),
    .pin_i(sync0_r[1]),
    .wr_i(wr_c0),
    .wdata_i(wb_dat_i[7:0]),
    .count_o(cnt0),
    .ovf_o(ovf0),
    .done_o(done0)
  );

  dtec_channel u_ch1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .mode_i(ctl1_r[DTEC_BIT_MODE_HI:DTEC_BIT_MODE_LO]),
    .run_i(ctl1_r[DTEC_BIT_RUN]),
    .edge_sel_i(ctl1_r[DTEC_BIT_EDGE]),
    .tick_i(tick1),
    .hold_i(hold1),
    .pin_i(sync1_r[1]),
    .wr_i(wr_c1),
    .wdata_i(wb_dat_i[7:0]),
    .count_o(cnt1),
    .ovf_o(ovf1),
    .done_o(done1)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // bus checks

  // a request that is taken is always answered at the very next edge
  sequence s_req_taken;
    req;
  endsequence

  sequence s_answer;
    wb_ack_o || wb_err_o;
  endsequence

  sequence s_rd_cnt0;
    req && hit_c0 && !wb_we_i;
  endsequence

  sequence s_rd_cnt1;
    req && hit_c1 && !wb_we_i;
  endsequence

  sequence s_bad_write;
    req && !hit && wb_we_i && !done0 && !done1;
  endsequence

  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");

  a_err_one: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_err_o |=> !wb_err_o) else $error("err longer than one cycle");

  a_ack_err_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wb_ack_o && wb_err_o)) else $error("ack and err together");

  a_req_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    s_req_taken |=> s_answer) else $error("request not answered");

  a_rd_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits nonzero");

  // the value read back is the live count at the edge the request is taken
  a_rd_count0: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_cnt0 |=> wb_dat_o[7:0] == $past(cnt0))
    else $error("counter0 read not live count");

  a_rd_count1: assert property (@(posedge clk_i) disable iff (rst_i)
    s_rd_cnt1 |=> wb_dat_o[7:0] == $past(cnt1))
    else $error("counter1 read not live count");

  // an unmapped write must not reach any control register
  a_bad_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    s_bad_write |=> $stable(ctl0_r) && $stable(ctl1_r))
    else $error("unmapped write changed control");

  ////////////////////////////////////////////////////////////////////////////////
  // control register checks

  a_ctl_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && hit_k0 && !wb_we_i |-> wb_dat_o[2:0] == 3'h0)
    else $error("unused control bits nonzero");

  a_ctl1_low_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && hit_k1 && !wb_we_i |-> wb_dat_o[2:0] == 3'h0)
    else $error("unused control1 bits nonzero");

  a_ctl0_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_k0 |=> ctl0_r == {$past(wb_dat_i[7:3]), 3'h0})
    else $error("control0 write lost");

  a_ctl1_write: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_k1 |=> ctl1_r == {$past(wb_dat_i[7:3]), 3'h0})
    else $error("control1 write lost");

  // only software or a finished measurement may touch the control bits
  a_ctl0_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_k0 && !done0 |=> $stable(ctl0_r))
    else $error("control0 changed on its own");

  a_ctl1_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    !wr_k1 && !done1 |=> $stable(ctl1_r))
    else $error("control1 changed on its own");

  a_pulse_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    done0 && !wr_k0 |=> !ctl0_r[DTEC_BIT_RUN]) else $error("run not cleared");

  a_pulse_clear1: assert property (@(posedge clk_i) disable iff (rst_i)
    done1 && !wr_k1 |=> !ctl1_r[DTEC_BIT_RUN]) else $error("run1 not cleared");

  ////////////////////////////////////////////////////////////////////////////////
  // clock source checks

  // the divided clock is a one-in-four enable, never a wider pulse
  a_div_period: assert property (@(posedge clk_i) disable iff (rst_i)
    sys_q |=> !sys_q [*3] ##1 sys_q)
    else $error("divided clock period wrong");

  a_tick0_rtc: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl0_r[DTEC_BIT_CSEL] |-> tick0 == rtc_tick_i)
    else $error("counter0 not on rtc");

  a_tick0_sys: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl0_r[DTEC_BIT_CSEL] |-> tick0 == c0_sys)
    else $error("counter0 not on system clock");

  a_tick1_opt: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl1_r[DTEC_BIT_CSEL] |-> tick1 == c1_opt)
    else $error("counter1 not on option source");

  a_tick1_div: assert property (@(posedge clk_i) disable iff (rst_i)
    ctl1_r[DTEC_BIT_CSEL] |-> tick1 == sys_q)
    else $error("counter1 not on divided clock");

  // a pin reaches the channel only through both synchroniser stages
  a_sync0_chain: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sync0_r[1] == $past(sync0_r[0]))
    else $error("pin0 skipped a stage");

  a_sync1_chain: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1 |=> sync1_r[1] == $past(sync1_r[0]))
    else $error("pin1 skipped a stage");

  ////////////////////////////////////////////////////////////////////////////////
  // overflow request checks

  a_ovf0_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf0 |=> counter0_ovf_o) else $error("overflow0 flag missing");

  a_ovf_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    ovf1 |=> counter1_ovf_o) else $error("overflow flag missing");

  a_ovf0_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !ovf0 |=> !counter0_ovf_o) else $error("spurious overflow0 flag");

  a_ovf1_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !ovf1 |=> !counter1_ovf_o) else $error("spurious overflow1 flag");
endmodule

// ==== tb/dtec_pin_src.sv ====
// dtec_pin_src: behavioural source of pulses on a counter input pin
// assumes the bench pulses start_i for one cycle while busy_o is low
`timescale 1ns/10ps
module dtec_pin_src (
  // control from bench
  input wire logic clk_i,
  input wire logic start_i,
  input wire logic [7:0] num_i,
  input wire logic [7:0] wid_i,
  // pin drive
  output logic pin_o,
  output logic busy_o
);
  logic [8:0] half_r;
  logic [7:0] left_r;
  initial begin
    pin_o = 1'b0;
    half_r = 9'h000;
    left_r = 8'h00;
  end
  assign busy_o = (half_r != 9'h000);
  // each pulse is two half periods of wid_i cycles, so the pin ends at its idle level
  always @(posedge clk_i) begin
    if (start_i) begin
      half_r <= {num_i, 1'b0};
      left_r <= wid_i;
    end else if (busy_o) begin
      if (left_r == 8'h01) begin
        pin_o <= ~pin_o;
        half_r <= half_r - 9'h001;
        left_r <= wid_i;
      end else begin
        left_r <= left_r - 8'h01;
      end
    end
  end
endmodule

// ==== tb/dual_timer_event_counter_tb.sv ====
// dual_timer_event_counter_tb: register level tests of the dual timer
// assumes default build options: counter0 on system clock, counter1 on overflow0
`timescale 1ns/10ps
module dual_timer_event_counter_tb;
  import dtec_pkg::*;
  logic clk_i, rst_i, cyc, stb, we, rtc, go, inv0, ack, err, ovf0, pin, busy, e;
  logic [7:0] adr, num, wid, q, pw_keep;
  logic [31:0] wdat, rdat;
  int fail_count, checks_done, cyc_n, i;
  dtec_top u_dtec_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .rtc_tick_i(rtc), .tbase_tick_i(1'b0),
    .counter0_pin_i(pin ^ inv0), .counter1_pin_i(pin), .counter0_ovf_o(ovf0),
    .counter1_ovf_o());
  dtec_pin_src u_dtec_pin_src (.clk_i(clk_i), .start_i(go), .num_i(num), .wid_i(wid),
    .pin_o(pin), .busy_o(busy));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // the ceiling is far above the several hundred cycles the tests take
  always @(posedge clk_i) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge clk_i); while (!(ack | err));
    q = rdat[7:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(q, exp);
  endtask
  task automatic pulse(input logic [7:0] n, input logic [7:0] w);
    @(posedge clk_i);
    num <= n;
    wid <= w;
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    @(posedge clk_i);
    while (busy) @(posedge clk_i);
    repeat (8) @(posedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {cyc, stb, we, rtc, go, inv0, adr, num, wid, wdat} = '0;
    fail_count = 0;
    checks_done = 0;
    cyc_n = 0;
    rst_i = 1'b1;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(8'h38, 8'h08);
    rdc(8'h44, 8'h08);
    wr(8'h38, 8'hff);
    rdc(8'h38, 8'hf8);
    wr(8'h38, 8'h00);
    wr(8'h34, 8'h5a);
    rdc(8'h34, 8'h5a);
    wr(8'h38, 8'h30);
    repeat (20) @(posedge clk_i);
    rdc(8'h34, 8'h5a);
    wr(8'h38, 8'ha0);
    repeat (20) @(posedge clk_i);
    rdc(8'h34, 8'h5a);
    bus(1'b0, 8'h00, 8'h00);
    chk({7'h00, e}, 8'h01);
    $display("test registers done");
    wr(8'h40, 8'h00);
    wr(8'h34, 8'hf0);
    wr(8'h44, 8'h90);
    wr(8'h38, 8'hb0);
    // preload written while running must not disturb the count
    wr(8'h34, 8'h80);
    for (i = 0; i < 64 && ovf0 !== 1'b1; i++) @(posedge clk_i);
    chk({7'h00, ovf0}, 8'h01);
    wr(8'h38, 8'h20);
    wr(8'h44, 8'h00);
    bus(1'b0, 8'h34, 8'h00);
    chk({7'h00, (q >= 8'h80 && q < 8'h90)}, 8'h01);
    rdc(8'h40, 8'h01);
    $display("test timer overflow done");
    wr(8'h34, 8'h00);
    wr(8'h38, 8'h90);
    pulse(8'h03, 8'h02);
    repeat (3) begin
      @(posedge clk_i);
      rtc <= 1'b1;
      @(posedge clk_i);
      rtc <= 1'b0;
    end
    repeat (2) @(posedge clk_i);
    rdc(8'h34, 8'h03);
    $display("test rtc source done");
    for (i = 0; i < 2; i++) begin
      wr(8'h44, 8'h00);
      wr(8'h40, 8'h00);
      wr(8'h44, 8'(8'h50 | (i << 3)));
      @(posedge clk_i);
      num <= 8'h01;
      wid <= 8'd20;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      repeat (28) @(posedge clk_i);
      rdc(8'h40, 8'(1 - i));
      while (busy) @(posedge clk_i);
      repeat (8) @(posedge clk_i);
      rdc(8'h40, 8'h01);
    end
    $display("test event count done");
    for (i = 0; i < 2; i++) begin
      wr(8'h38, 8'h00);
      inv0 <= ~i[0];
      repeat (4) @(posedge clk_i);
      wr(8'h34, 8'h00);
      wr(8'h38, 8'(8'hf0 | (i << 3)));
      pulse(8'h01, 8'd10);
      bus(1'b0, 8'h34, 8'h00);
      chk({7'h00, (q >= 8'd9 && q <= 8'd11)}, 8'h01);
      pw_keep = q;
      rdc(8'h38, 8'(8'he0 | (i << 3)));
      pulse(8'h01, 8'd10);
      rdc(8'h34, pw_keep);
    end
    $display("test pulse width done");
    stop_test();
  end
endmodule
